// File: common/paf_pkg.sv
package paf_pkg;

  // ************************************************************
  // Port geometry
  // ************************************************************
  localparam int unsigned PAF_NUM_PINS  = 8;
  localparam int unsigned PAF_DATA_W    = 32;
  localparam int unsigned PAF_ADDR_W    = 8;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] PAF_OFS_DIR    = 8'h00;
  localparam logic [7:0] PAF_OFS_OUT    = 8'h04;
  localparam logic [7:0] PAF_OFS_PIN    = 8'h08;
  localparam logic [7:0] PAF_OFS_CTRL   = 8'h0C;
  localparam logic [7:0] PAF_OFS_PCMASK = 8'h10;
  localparam logic [7:0] PAF_OFS_ADCDIS = 8'h14;
  localparam logic [7:0] PAF_OFS_STATUS = 8'h18;

  // ************************************************************
  // Control register fields
  // ************************************************************
  localparam int unsigned PAF_CTRL_PUD_BIT  = 0;
  localparam int unsigned PAF_CTRL_PCIE_BIT = 1;
  localparam int unsigned PAF_CTRL_W        = 2;

  // ************************************************************
  // Status register fields
  // ************************************************************
  localparam int unsigned PAF_STAT_DIE_LSB  = 0;
  localparam int unsigned PAF_STAT_PU_LSB   = 8;
  localparam int unsigned PAF_STAT_OE_LSB   = 16;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] PAF_RST_DIR    = 8'h00;
  localparam logic [7:0] PAF_RST_OUT    = 8'h00;
  localparam logic [7:0] PAF_RST_PCMASK = 8'h00;
  localparam logic [7:0] PAF_RST_ADCDIS = 8'h00;
  localparam logic [1:0] PAF_RST_CTRL   = 2'h0;

  // Port A has no pull-up, direction or value overrides
  localparam logic [7:0] PAF_PORTA_TIE  = 8'h00;

  // ************************************************************
  // Sleep controller modes
  // ************************************************************
  typedef enum logic [2:0] {
    PAF_SLP_IDLE,
    PAF_SLP_ADC_NR,
    PAF_SLP_POWER_DOWN,
    PAF_SLP_POWER_SAVE,
    PAF_SLP_STANDBY,
    PAF_SLP_EXT_STANDBY
  } paf_sleep_mode_t;

endpackage

// File: design/paf_pin_cell.sv
`timescale 1ns/100ps
module paf_pin_cell (
  input  wire logic dir_bit,
  input  wire logic out_bit,
  input  wire logic global_pullup_disable,
  input  wire logic sleep,
  input  wire logic pullup_override_en,
  input  wire logic pullup_override_val,
  input  wire logic dir_override_en,
  input  wire logic dir_override_val,
  input  wire logic value_override_en,
  input  wire logic value_override_val,
  input  wire logic input_enable_override_en,
  input  wire logic input_enable_override_val,
  input  wire logic pad_level,
  output logic      pullup_en,
  output logic      drive_en,
  output logic      drive_val,
  output logic      input_en,
  output logic      raw_digital_in
);

  // ************************************************************
  // Override multiplexers, no clock anywhere
  // ************************************************************
  wire logic plain_pullup;
  assign plain_pullup   = ({dir_bit, out_bit, global_pullup_disable} == 3'h2);
  assign pullup_en      = pullup_override_en ? pullup_override_val : plain_pullup;
  assign drive_en       = dir_override_en ? dir_override_val : dir_bit;
  // Value only reaches the pad while drive_en is high
  assign drive_val      = value_override_en ? value_override_val : out_bit;
  assign input_en       = input_enable_override_en ? input_enable_override_val : ~sleep;
  // Clamp to ground ahead of the Schmitt trigger
  assign raw_digital_in = pad_level & input_en;

endmodule

// File: design/paf_port_a.sv
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module paf_port_a
  import paf_pkg::*;
#(
  parameter int unsigned NPINS = PAF_NUM_PINS
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [PAF_ADDR_W-1:0] paddr,
  input  wire logic [PAF_DATA_W-1:0] pwdata,
  output logic      [PAF_DATA_W-1:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  sleep_active,
  input  wire logic [2:0]            sleep_mode,
  input  wire logic [NPINS-1:0]      pad_level,
  output logic      [NPINS-1:0]      pad_out,
  output logic      [NPINS-1:0]      pad_oe,
  output logic      [NPINS-1:0]      pad_pullup_en,
  output logic      [NPINS-1:0]      pin_change_in,
  output logic      [NPINS-1:0]      adc_channel_in
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [NPINS-1:0]      dir_r;
  logic [NPINS-1:0]      dir_nxt;
  logic [NPINS-1:0]      out_r;
  logic [NPINS-1:0]      out_nxt;
  logic [NPINS-1:0]      pcmask_r;
  logic [NPINS-1:0]      pcmask_nxt;
  logic [NPINS-1:0]      adcdis_r;
  logic [NPINS-1:0]      adcdis_nxt;
  logic [PAF_CTRL_W-1:0] ctrl_r;
  logic [PAF_CTRL_W-1:0] ctrl_nxt;
  logic [PAF_DATA_W-1:0] prdata_r;
  logic [PAF_DATA_W-1:0] prdata_nxt;
  logic                  pready_r;
  logic                  pslverr_r;
  logic                  pslverr_nxt;
  logic [NPINS-1:0]      sync1_r;
  logic [NPINS-1:0]      sync2_r;
  logic [NPINS-1:0]      sync3_r;
  logic [NPINS-1:0]      pin_state_r;
  logic [NPINS-1:0]      pin_state_nxt;
  logic                  sleep_r;
  logic                  sleep_nxt;

  // ************************************************************
  // Bus decode
  // ************************************************************
  wire logic             access;
  wire logic             bus_done;
  wire logic             port_write_strobe;
  wire logic             bus_read;
  wire logic             hit_dir;
  wire logic             hit_out;
  wire logic             hit_pin;
  wire logic             hit_ctrl;
  wire logic             hit_pcmask;
  wire logic             hit_adcdis;
  wire logic             hit_status;
  wire logic             hit_any;
  wire logic [NPINS-1:0] wbyte;

  assign access            = psel & penable;
  // Answer one cycle into the access phase so read data is a flop
  assign bus_done          = access & pready_r;
  assign port_write_strobe = bus_done & pwrite & hit_any;
  assign bus_read          = access & ~pready_r & ~pwrite;
  assign hit_dir           = (paddr == PAF_OFS_DIR);
  assign hit_out           = (paddr == PAF_OFS_OUT);
  assign hit_pin           = (paddr == PAF_OFS_PIN);
  assign hit_ctrl          = (paddr == PAF_OFS_CTRL);
  assign hit_pcmask        = (paddr == PAF_OFS_PCMASK);
  assign hit_adcdis        = (paddr == PAF_OFS_ADCDIS);
  assign hit_status        = (paddr == PAF_OFS_STATUS);
  assign hit_any           = hit_dir | hit_out | hit_pin | hit_ctrl | hit_pcmask | hit_adcdis | hit_status;
  assign wbyte             = pwdata[NPINS-1:0];

  // ************************************************************
  // Shared controls
  // ************************************************************
  wire logic global_pullup_disable;
  wire logic pin_change_group_a_enable;
  wire logic deep_sleep;

  assign global_pullup_disable     = ctrl_r[PAF_CTRL_PUD_BIT];
  assign pin_change_group_a_enable = ctrl_r[PAF_CTRL_PCIE_BIT];
  assign deep_sleep = sleep_active &
                      ((sleep_mode == PAF_SLP_POWER_DOWN) | (sleep_mode == PAF_SLP_STANDBY) |
                       (sleep_mode == PAF_SLP_EXT_STANDBY));
  assign sleep_nxt  = deep_sleep;

  // ************************************************************
  // Per-pin override signals for port A
  // ************************************************************
  wire logic [NPINS-1:0] pin_change_mask_bit;
  wire logic [NPINS-1:0] analog_channel_input_disable;
  wire logic [NPINS-1:0] pc_term;
  wire logic [NPINS-1:0] input_enable_override_en;
  wire logic [NPINS-1:0] input_enable_override_val;
  wire logic [NPINS-1:0] pullup_override_en;
  wire logic [NPINS-1:0] pullup_override_val;
  wire logic [NPINS-1:0] dir_override_en;
  wire logic [NPINS-1:0] dir_override_val;
  wire logic [NPINS-1:0] value_override_en;
  wire logic [NPINS-1:0] value_override_val;
  wire logic [NPINS-1:0] cell_pullup;
  wire logic [NPINS-1:0] cell_drive_en;
  wire logic [NPINS-1:0] cell_drive_val;
  wire logic [NPINS-1:0] cell_input_en;
  wire logic [NPINS-1:0] raw_digital_in;

  assign pin_change_mask_bit          = pcmask_r;
  assign analog_channel_input_disable = adcdis_r;
  assign pc_term                   = pin_change_mask_bit & {NPINS{pin_change_group_a_enable}};
  assign input_enable_override_en  = pc_term | analog_channel_input_disable;
  assign input_enable_override_val = pc_term;
  // Port A peripherals never own the pad drive or pull-up
  assign pullup_override_en  = PAF_PORTA_TIE[NPINS-1:0];
  assign pullup_override_val = PAF_PORTA_TIE[NPINS-1:0];
  assign dir_override_en     = PAF_PORTA_TIE[NPINS-1:0];
  assign dir_override_val    = PAF_PORTA_TIE[NPINS-1:0];
  assign value_override_en   = PAF_PORTA_TIE[NPINS-1:0];
  assign value_override_val  = PAF_PORTA_TIE[NPINS-1:0];

  // ************************************************************
  // Pin cells
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      paf_pin_cell u_cell (
        .dir_bit                   (dir_r[gi]),
        .out_bit                   (out_r[gi]),
        .global_pullup_disable     (global_pullup_disable),
        .sleep                     (sleep_r),
        .pullup_override_en        (pullup_override_en[gi]),
        .pullup_override_val       (pullup_override_val[gi]),
        .dir_override_en           (dir_override_en[gi]),
        .dir_override_val          (dir_override_val[gi]),
        .value_override_en         (value_override_en[gi]),
        .value_override_val        (value_override_val[gi]),
        .input_enable_override_en  (input_enable_override_en[gi]),
        .input_enable_override_val (input_enable_override_val[gi]),
        .pad_level                 (pad_level[gi]),
        .pullup_en                 (cell_pullup[gi]),
        .drive_en                  (cell_drive_en[gi]),
        .drive_val                 (cell_drive_val[gi]),
        .input_en                  (cell_input_en[gi]),
        .raw_digital_in            (raw_digital_in[gi])
      );
    end
  endgenerate

  // Pad controls stay combinational so overrides act at once
  assign pad_pullup_en  = cell_pullup;
  assign pad_oe         = cell_drive_en;
  assign pad_out        = cell_drive_val;
  // Unsynchronized tap; the pin-change logic synchronizes it itself
  assign pin_change_in  = raw_digital_in;
  // Stand-in for the direct analog pad path
  assign adc_channel_in = pad_level;

  // ************************************************************
  // Register next-state
  // ************************************************************
  assign dir_nxt    = (port_write_strobe & hit_dir) ? wbyte : dir_r;
  // Writing ones to the pin register toggles the output bits
  assign out_nxt    = (port_write_strobe & hit_out) ? wbyte :
                      (port_write_strobe & hit_pin) ? (out_r ^ wbyte) : out_r;
  assign pcmask_nxt = (port_write_strobe & hit_pcmask) ? wbyte : pcmask_r;
  assign adcdis_nxt = (port_write_strobe & hit_adcdis) ? wbyte : adcdis_r;
  assign ctrl_nxt   = (port_write_strobe & hit_ctrl) ? pwdata[PAF_CTRL_W-1:0] : ctrl_r;

  // Own synchronizer: a change counts once stages two and three agree
  assign pin_state_nxt = (~(sync2_r ^ sync3_r) & sync3_r) | ((sync2_r ^ sync3_r) & pin_state_r);

  // ************************************************************
  // Read data
  // ************************************************************
  wire logic [PAF_DATA_W-1:0] status_word;
  wire logic [PAF_DATA_W-1:0] rd_word;

  assign status_word = {{(PAF_DATA_W-PAF_STAT_OE_LSB-NPINS){1'b0}}, cell_drive_en,
                        cell_pullup, cell_input_en};
  assign rd_word = hit_dir    ? {{(PAF_DATA_W-NPINS){1'b0}}, dir_r} :
                   hit_out    ? {{(PAF_DATA_W-NPINS){1'b0}}, out_r} :
                   hit_pin    ? {{(PAF_DATA_W-NPINS){1'b0}}, pin_state_r} :
                   hit_ctrl   ? {{(PAF_DATA_W-PAF_CTRL_W){1'b0}}, ctrl_r} :
                   hit_pcmask ? {{(PAF_DATA_W-NPINS){1'b0}}, pcmask_r} :
                   hit_adcdis ? {{(PAF_DATA_W-NPINS){1'b0}}, adcdis_r} :
                   hit_status ? status_word : 32'h0000_0000;
  assign prdata_nxt  = bus_read ? rd_word : prdata_r;
  assign pslverr_nxt = access & ~pready_r & ~hit_any;

  // ************************************************************
  // Flip-flops
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r    <= PAF_RST_DIR;
      out_r    <= PAF_RST_OUT;
      pcmask_r <= PAF_RST_PCMASK;
      adcdis_r <= PAF_RST_ADCDIS;
      ctrl_r   <= PAF_RST_CTRL;
    end else begin
      dir_r    <= dir_nxt;
      out_r    <= out_nxt;
      pcmask_r <= pcmask_nxt;
      adcdis_r <= adcdis_nxt;
      ctrl_r   <= ctrl_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= access & ~pready_r;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r     <= '0;
      sync2_r     <= '0;
      sync3_r     <= '0;
      pin_state_r <= '0;
      sleep_r     <= 1'b0;
    end else begin
      sync1_r     <= pad_level;
      sync2_r     <= sync1_r;
      sync3_r     <= sync2_r;
      pin_state_r <= pin_state_nxt;
      sleep_r     <= sleep_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

endmodule

// File: tb/paf_pad_model.sv
`timescale 1ns/100ps
module paf_pad_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pullup_en,
  input  wire logic [7:0] ext_drive,
  input  wire logic [7:0] ext_level,
  input  wire logic [7:0] pin_change_in,
  output logic      [7:0] pad_level,
  output logic      [7:0] pc_sync
);
  logic [7:0] float_r;
  logic [7:0] sync1_r;

  // Undriven pad wanders every cycle so no stale level passes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      float_r <= 8'h00;
    end else begin
      float_r <= ~float_r;
    end
  end
  assign pad_level = (pad_oe & pad_out) | (~pad_oe & ext_drive & ext_level)
                   | (~pad_oe & ~ext_drive & (pad_pullup_en | float_r));

  // Pin-change consumer brings the raw input into its own domain
  always_ff @(posedge pclk) begin
    sync1_r <= pin_change_in;
    pc_sync <= sync1_r;
  end
endmodule

// File: tb/paf_port_a_monitor.sv
`timescale 1ns/100ps
module paf_port_a_monitor
  import paf_pkg::*;
#(
  parameter int unsigned NPINS = PAF_NUM_PINS
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [PAF_ADDR_W-1:0] paddr,
  input wire logic [PAF_DATA_W-1:0] pwdata,
  input wire logic [PAF_DATA_W-1:0] prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  sleep_active,
  input wire logic [2:0]            sleep_mode,
  input wire logic [NPINS-1:0]      pad_level,
  input wire logic [NPINS-1:0]      pad_out,
  input wire logic [NPINS-1:0]      pad_oe,
  input wire logic [NPINS-1:0]      pad_pullup_en,
  input wire logic [NPINS-1:0]      pin_change_in,
  input wire logic [NPINS-1:0]      adc_channel_in
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ********
  // Pin path
  // ********
  pull_drive_excl_a: assert property ((pad_pullup_en & pad_oe) == '0)
    else $error("pull-up on while driving");
  analog_path_a: assert property (adc_channel_in == pad_level)
    else $error("analog tap differs from pad");
  input_clamp_a: assert property ((pin_change_in & ~pad_level) == '0)
    else $error("digital input high on low pad");
  // No register write, no pin control change
  ctrl_hold_a: assert property (!$past(psel) |-> $stable(pad_oe) && $stable(pad_pullup_en))
    else $error("pin control changed without write");
  reset_quiet_a: assert property (disable iff (1'b0) !presetn |-> pad_oe == '0 && pad_pullup_en == '0 && !pready)
    else $error("outputs active in reset");

  // ********
  // Bus answer
  // ********
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_timing_a: assert property ($rose(penable) && psel |=> pready)
    else $error("ready not one cycle into access");
  ready_cause_a: assert property (pready |-> psel && penable && $past(penable))
    else $error("ready outside access phase");
  error_pulse_a: assert property (pslverr |-> pready)
    else $error("error without ready");

  cover property (pready && pslverr);
  cover property (sleep_active && pin_change_in != '0);
  cover property (pad_pullup_en != '0);
endmodule

// File: tb/port_alt_function_override_tb.sv
`timescale 1ns/100ps
module port_alt_function_override_tb;
  import paf_pkg::*;
  logic        pclk, pready, pslverr;
  logic        presetn, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_active = 1'b0;
  logic [7:0]  paddr = 8'h00, ext_drive = 8'hFF, ext_level = 8'hC3;
  logic [2:0]  sleep_mode = 3'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic [7:0]  pad_level, pad_out, pad_oe, pad_pullup_en, pin_change_in, adc_channel_in, pc_sync;
  logic        err;
  int          miscompares = 0, num_checks = 0;

  paf_port_a #(.NPINS(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_active(sleep_active), .sleep_mode(sleep_mode), .pad_level(pad_level), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en), .pin_change_in(pin_change_in),
    .adc_channel_in(adc_channel_in));
  paf_pad_model pads (.pclk(pclk), .presetn(presetn), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_en(pad_pullup_en), .ext_drive(ext_drive), .ext_level(ext_level),
    .pin_change_in(pin_change_in), .pad_level(pad_level), .pc_sync(pc_sync));

  // ********
  // Helpers
  // ********
  task results;
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Answer taken at the rising edge that samples pready high, then released
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd_data, output logic rd_err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdata, err);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rdata, err);
    check(rdata, exp);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    #2000000;
    miscompares++;
    results();
  end

  // ********
  // Tests
  // ********
  initial begin
    logic [7:0] dir, pc, ie, pu, lvl;
    logic       slp;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd(8'(4 * i), i == 6 ? 32'h0000_00FF : (i == 2 ? 32'h0000_00C3 : 32'h0));
    for (int k = 0; k < 4; k++) begin
      dir = 8'h5A ^ {8{k[0]}};
      wr(PAF_OFS_DIR, {24'h0, dir});
      wr(PAF_OFS_OUT, 32'h0000_003C);
      wr(PAF_OFS_CTRL, {31'h0, k[1]});
      pu = ~dir & 8'h3C & ~{8{k[1]}};
      // Pull-up pins left undriven must read high
      lvl = (dir & 8'h3C) | (~dir & 8'hC3) | pu;
      ext_drive <= ~pu;
      @(negedge pclk);
      check(pad_oe, dir);
      check(pad_out & dir, 8'h3C & dir);
      check(pad_pullup_en, pu);
      check(adc_channel_in, lvl);
      rd(PAF_OFS_STATUS, {8'h00, dir, pu, 8'hFF});
      rd(PAF_OFS_PIN, {24'h0, lvl});
    end
    ext_drive <= 8'hFF;
    wr(PAF_OFS_PIN, 32'h0000_000F);
    rd(PAF_OFS_OUT, 32'h0000_0033);
    wr(PAF_OFS_DIR, 32'h0);
    wr(PAF_OFS_PCMASK, 32'h0000_001E);
    wr(PAF_OFS_ADCDIS, 32'h0000_0030);
    for (int p = 0; p < 2; p++) begin
      wr(PAF_OFS_CTRL, {30'h0, p[0], 1'b0});
      pc = 8'h1E & {8{p[0]}};
      for (int s = 0; s < 2; s++) begin
        for (int m = 0; m < 6; m++) begin
          slp = s[0] && (m inside {PAF_SLP_POWER_DOWN, PAF_SLP_STANDBY, PAF_SLP_EXT_STANDBY});
          ie = pc | (~(pc | 8'h30) & {8{!slp}});
          lvl = 8'h96 ^ 8'(m * 16 + s * 4 + p);
          @(posedge pclk);
          sleep_active <= s[0];
          sleep_mode <= 3'(m);
          repeat (2) @(posedge pclk);
          ext_level <= lvl;
          @(negedge pclk);
          check(pin_change_in, lvl & ie);
          rd(PAF_OFS_STATUS, {16'h0, 8'h33, ie});
          @(negedge pclk);
          check(pc_sync, lvl & ie);
        end
      end
    end
    apb(1'b1, 8'h1C, 32'h0000_00FF, rdata, err);
    check(err, 1'b1);
    apb(1'b0, 8'h1C, 32'h0, rdata, err);
    check(rdata, 32'h0);
    check(err, 1'b1);
    rd(PAF_OFS_DIR, 32'h0);
    results();
  end
endmodule

bind paf_port_a paf_port_a_monitor #(.NPINS(NPINS)) u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep_active(sleep_active), .sleep_mode(sleep_mode), .pad_level(pad_level),
  .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en), .pin_change_in(pin_change_in),
  .adc_channel_in(adc_channel_in));
